// ===== ccr_pkg.sv
// Purpose: Shared constants and types for the CPU control register set
// Assumes: AHB-Lite word map, byte offsets below
// Notes: Stack data is carried as one word, lowest address in bits 7:0
package ccr_pkg;
	localparam int PC_W = 20;
	localparam logic [7:0] FLAGS_RST = 8'h06;
	localparam logic [15:0] SP_RST = 16'h0000;
	localparam logic [15:0] SP_EVEN = 16'hfffe;
	localparam logic [3:0] DEXT_RST = 4'hf;
	localparam logic [3:0] CEXT_RST = 4'h0;
	localparam logic [3:0] DATA_TOP = 4'hf;
	localparam logic [19:0] WREG_LO = 20'hffee0;
	localparam logic [19:0] WREG_HI = 20'hffeff;
	// Flag word bit positions
	localparam int FB_IE = 7;
	localparam int FB_Z = 6;
	localparam int FB_RB1 = 5;
	localparam int FB_AC = 4;
	localparam int FB_RB0 = 3;
	localparam int FB_IS1 = 2;
	localparam int FB_IS0 = 1;
	localparam int FB_CY = 0;
	// Register byte offsets
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_SP = 8'h04;
	localparam logic [7:0] OFS_DEXT = 8'h08;
	localparam logic [7:0] OFS_CEXT = 8'h0c;
	localparam logic [7:0] OFS_PC = 8'h10;
	localparam logic [7:0] OFS_DADDR = 8'h14;
	localparam logic [7:0] OFS_WREG = 8'h40;
	localparam logic [7:0] OFS_PAIR = 8'hc0;
	localparam logic [7:0] OFS_END = 8'hd0;
	// Stack frame sizes
	localparam logic [15:0] SP_FOUR = 16'h0004;
	localparam logic [15:0] SP_TWO = 16'h0002;
	localparam logic [2:0] LEN_FOUR = 3'h4;
	localparam logic [2:0] LEN_TWO = 3'h2;
	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_SEQ = 4'h1, OP_BR = 4'h2, OP_BR_REG = 4'h3,
		OP_CALL = 4'h4, OP_PUSH_PAIR = 4'h5, OP_PUSH_FLAGS = 4'h6,
		OP_POP_FLAGS = 4'h7, OP_RET_INT = 4'h8, OP_ALU = 4'h9,
		OP_CARRY = 4'ha, OP_SEL_BANK = 4'hb, OP_DI = 4'hc, OP_EI = 4'hd,
		OP_LOAD_SP = 4'he, OP_DADDR = 4'hf
	} ccr_op_type;
	typedef enum logic [1:0] {
		ST_BOOT = 2'h0,
		ST_RUN = 2'h1
	} ccr_state_type;
endpackage

// ===== ccr_core.sv
// Purpose: Program counter, flag word, stack pointer, banks and extensions
// Assumes: Execution logic on hclk issues one op per cycle; AHB-Lite access
// Notes: Ops win over interrupt acknowledge; bus writes land after ops
// What this block does
// - Twenty-bit program counter advances by each instruction's byte length.
// - A branch loads the counter from immediate or register target.
// - After reset the counter loads the vector from bytes 00000H and 00001H.
// - Flag word resets to 06H with the documented bit order.
// - Flags are pushed on acknowledge or flag push, restored by returns and pop.
// - With interrupts disabled, no maskable request is acknowledged.
// - With interrupts enabled, in-service level, mask and priority gate acknowledge.
// - Disable and any acknowledge clear the enable flag; enable sets it.
// - Zero flag is one for a zero result, otherwise zero.
// - Two-bit bank field picks one of four banks, set by bank select.
// - Auxiliary carry follows carry out of or borrow into bit 3.
// - A request below the in-service level is never acknowledged.
// - Carry holds add/subtract carry, rotate shift-out and bit accumulator.
// - Stack pointer is sixteen bits with bit 0 always zero.
// - Pointer decrements before stack writes and increments after reads.
// - A call lowers the pointer by four, storing counter bytes then zero.
// - Four banks of eight bytes, mapped FFEE0H to FFEFFH, pair into words.
// - Data extension resets to 0FH, code extension to 00H, four bits each.
// - Plain data addresses sit in F0000H to FFFFFH; prefix supplies upper bits.
// - Register-indirect branches take their upper four bits from code extension.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module ccr_core (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [7:0] reset_vec_lo,
	input wire logic [7:0] reset_vec_hi,
	input wire logic op_valid,
	input wire logic [3:0] op_code,
	input wire logic [31:0] op_data,
	input wire logic irq_req,
	input wire logic irq_masked,
	input wire logic [1:0] irq_prio,
	input wire logic [15:0] irq_vector,
	output logic irq_ack,
	output logic core_ready,
	output logic [19:0] pc_out,
	output logic [7:0] flags_out,
	output logic [15:0] sp_out,
	output logic stk_we,
	output logic [15:0] stk_addr,
	output logic [31:0] stk_wdata,
	output logic [2:0] stk_len,
	output logic [19:0] data_addr,
	output logic data_is_wreg
);
	typedef struct packed {
		ccr_pkg::ccr_state_type st;
		logic [19:0] pc;
		logic [7:0] flags;
		logic [15:0] sp;
		logic [3:0] dext;
		logic [3:0] cext;
		logic [31:0][7:0] wreg;
		logic wr_pend;
		logic [7:0] waddr;
		logic [31:0] rdata;
		logic rdy;
		logic resp;
		logic ack;
		logic stk_we;
		logic [15:0] stk_addr;
		logic [31:0] stk_wdata;
		logic [2:0] stk_len;
		logic [19:0] daddr;
		logic dwreg;
		logic run;
	} ccr_regs_type;

	ccr_regs_type q;
	ccr_regs_type d;

	// Next state: ops first, then bus write, then read data from the result
	always_comb begin
		logic [1:0] bank;
		logic [1:0] isp;
		logic int_ok;
		logic [7:0] ra;
		logic [7:0] wi;
		logic [31:0] rd;
		bank = {q.flags[ccr_pkg::FB_RB1], q.flags[ccr_pkg::FB_RB0]};
		isp = {q.flags[ccr_pkg::FB_IS1], q.flags[ccr_pkg::FB_IS0]};
		ra = 8'h00;
		wi = 8'h00;
		rd = 32'h0000_0000;
		int_ok = 1'b0;
		d = q;
		d.ack = 1'b0;
		d.stk_we = 1'b0;
		d.wr_pend = 1'b0;
		d.rdy = 1'b1;
		d.resp = 1'b0;
		// Lower number is the higher priority level
		int_ok = irq_req && !irq_masked && q.flags[ccr_pkg::FB_IE]
			&& (irq_prio <= isp);
		case (q.st)
			ccr_pkg::ST_BOOT: begin
				d.pc = {4'h0, reset_vec_hi, reset_vec_lo};
				d.st = ccr_pkg::ST_RUN;
				d.run = 1'b1;
			end
			ccr_pkg::ST_RUN: begin
				if (op_valid) begin
					case (op_code)
						ccr_pkg::OP_SEQ: d.pc = q.pc + {17'h0, op_data[2:0]};
						ccr_pkg::OP_BR: d.pc = op_data[19:0];
						ccr_pkg::OP_BR_REG: d.pc = {q.cext, op_data[15:0]};
						ccr_pkg::OP_CALL: begin
							// Decrement first, then write return address and a zero byte
							d.sp = q.sp - ccr_pkg::SP_FOUR;
							d.stk_we = 1'b1;
							d.stk_addr = d.sp;
							d.stk_wdata = {8'h00, 4'h0, q.pc};
							d.stk_len = ccr_pkg::LEN_FOUR;
							d.pc = op_data[19:0];
						end
						ccr_pkg::OP_PUSH_PAIR: begin
							d.sp = q.sp - ccr_pkg::SP_TWO;
							d.stk_we = 1'b1;
							d.stk_addr = d.sp;
							d.stk_wdata = {16'h0000, op_data[15:0]};
							d.stk_len = ccr_pkg::LEN_TWO;
						end
						ccr_pkg::OP_PUSH_FLAGS: begin
							d.sp = q.sp - ccr_pkg::SP_TWO;
							d.stk_we = 1'b1;
							d.stk_addr = d.sp;
							d.stk_wdata = {16'h0000, q.flags, 8'h00};
							d.stk_len = ccr_pkg::LEN_TWO;
						end
						ccr_pkg::OP_POP_FLAGS: begin
							d.flags = op_data[15:8];
							d.sp = q.sp + ccr_pkg::SP_TWO;
						end
						ccr_pkg::OP_RET_INT: begin
							d.pc = op_data[19:0];
							d.flags = op_data[31:24];
							d.sp = q.sp + ccr_pkg::SP_FOUR;
						end
						ccr_pkg::OP_ALU: begin
							d.flags[ccr_pkg::FB_Z] = op_data[16] ? (op_data[15:0] == 16'h0000)
								: (op_data[7:0] == 8'h00);
							d.flags[ccr_pkg::FB_CY] = op_data[17];
							d.flags[ccr_pkg::FB_AC] = op_data[18];
						end
						ccr_pkg::OP_CARRY: d.flags[ccr_pkg::FB_CY] = op_data[0];
						ccr_pkg::OP_SEL_BANK: begin
							d.flags[ccr_pkg::FB_RB1] = op_data[1];
							d.flags[ccr_pkg::FB_RB0] = op_data[0];
						end
						ccr_pkg::OP_DI: d.flags[ccr_pkg::FB_IE] = 1'b0;
						ccr_pkg::OP_EI: d.flags[ccr_pkg::FB_IE] = 1'b1;
						ccr_pkg::OP_LOAD_SP: d.sp = op_data[15:0] & ccr_pkg::SP_EVEN;
						ccr_pkg::OP_DADDR: begin
							d.daddr = {op_data[16] ? q.dext : ccr_pkg::DATA_TOP,
								op_data[15:0]};
							d.dwreg = (d.daddr >= ccr_pkg::WREG_LO)
								&& (d.daddr <= ccr_pkg::WREG_HI);
						end
						default: d.pc = q.pc; // No-op leaves every register as it was
					endcase
				end else if (int_ok) begin
					// Acknowledge only in an idle op cycle so the two never collide
					d.ack = 1'b1;
					d.sp = q.sp - ccr_pkg::SP_FOUR;
					d.stk_we = 1'b1;
					d.stk_addr = d.sp;
					d.stk_wdata = {q.flags, 4'h0, q.pc};
					d.stk_len = ccr_pkg::LEN_FOUR;
					d.flags[ccr_pkg::FB_IE] = 1'b0;
					d.flags[ccr_pkg::FB_IS1] = irq_prio[1];
					d.flags[ccr_pkg::FB_IS0] = irq_prio[0];
					d.pc = {4'h0, irq_vector};
				end
			end
			default: begin
				d.st = ccr_pkg::ST_BOOT;
				d.run = 1'b0;
			end
		endcase
		// Bus data phase write; only whole words are expected
		if (q.wr_pend) begin
			wi = q.waddr - ccr_pkg::OFS_WREG;
			case (q.waddr)
				ccr_pkg::OFS_FLAGS: d.flags = hwdata[7:0];
				ccr_pkg::OFS_SP: d.sp = hwdata[15:0] & ccr_pkg::SP_EVEN;
				ccr_pkg::OFS_DEXT: d.dext = hwdata[3:0];
				ccr_pkg::OFS_CEXT: d.cext = hwdata[3:0];
				ccr_pkg::OFS_PC: d.pc = hwdata[19:0];
				default: begin
					if (q.waddr >= ccr_pkg::OFS_WREG && q.waddr < ccr_pkg::OFS_PAIR) begin
						d.wreg[wi[6:2]] = hwdata[7:0];
					end
				end
			endcase
		end
		// Address phase: read data is formed from next state, but the pair window's bank comes from the current flags
		ra = haddr[7:0];
		wi = ra - ccr_pkg::OFS_WREG;
		case (ra)
			ccr_pkg::OFS_FLAGS: rd = {24'h0, d.flags};
			ccr_pkg::OFS_SP: rd = {16'h0, d.sp};
			ccr_pkg::OFS_DEXT: rd = {28'h0, d.dext};
			ccr_pkg::OFS_CEXT: rd = {28'h0, d.cext};
			ccr_pkg::OFS_PC: rd = {12'h0, d.pc};
			ccr_pkg::OFS_DADDR: rd = {11'h0, d.dwreg, d.daddr};
			default: begin
				if (ra >= ccr_pkg::OFS_WREG && ra < ccr_pkg::OFS_PAIR) begin
					rd = {24'h0, d.wreg[wi[6:2]]};
				end else if (ra >= ccr_pkg::OFS_PAIR && ra < ccr_pkg::OFS_END) begin
					// Pair of the current bank: odd register high, even low
					rd = {16'h0, d.wreg[{bank, ra[3:2], 1'b1}],
						d.wreg[{bank, ra[3:2], 1'b0}]};
				end
			end
		endcase
		if (hsel && htrans[1] && hready) begin
			d.wr_pend = hwrite;
			d.waddr = ra;
			d.rdata = rd;
		end
	end

	// State register; pointer resets to a defined even value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.st <= ccr_pkg::ST_BOOT;
			q.flags <= ccr_pkg::FLAGS_RST;
			q.sp <= ccr_pkg::SP_RST;
			q.dext <= ccr_pkg::DEXT_RST;
			q.cext <= ccr_pkg::CEXT_RST;
			q.rdy <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state flip-flops
	assign hreadyout = q.rdy;
	assign hrdata = q.rdata;
	assign hresp = q.resp;
	assign irq_ack = q.ack;
	assign core_ready = q.run;
	assign pc_out = q.pc;
	assign flags_out = q.flags;
	assign sp_out = q.sp;
	assign stk_we = q.stk_we;
	assign stk_addr = q.stk_addr;
	assign stk_wdata = q.stk_wdata;
	assign stk_len = q.stk_len;
	assign data_addr = q.daddr;
	assign data_is_wreg = q.dwreg;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic op_seq;
	logic op_call;
	assign op_seq = core_ready && op_valid;
	assign op_call = op_seq && (op_code == ccr_pkg::OP_CALL);
	// Op flag results other than the zero flag are only checked where no bus write lands on the same edge
	logic op_flags_free;
	assign op_flags_free = op_seq && !q.wr_pend;

	chk_seq_advance: assert property (op_seq && op_code == ccr_pkg::OP_SEQ
		|=> pc_out == $past(pc_out) + {17'h0, $past(op_data[2:0])})
		else $error("program counter did not advance by length");
	chk_branch_target: assert property (op_seq && op_code == ccr_pkg::OP_BR
		|=> pc_out == $past(op_data[19:0]))
		else $error("branch target not loaded");
	chk_boot_vector: assert property ($rose(core_ready)
		|-> pc_out == {4'h0, $past(reset_vec_hi), $past(reset_vec_lo)})
		else $error("reset vector not loaded");
	chk_flags_reset: assert property (!core_ready |-> flags_out == 8'h06)
		else $error("flag word reset value wrong");
	chk_di_blocks: assert property (!flags_out[ccr_pkg::FB_IE] |=> !irq_ack)
		else $error("acknowledge while disabled");
	chk_prio_gate: assert property (irq_ack
		|-> $past(irq_prio) <= $past(flags_out[2:1]) && !$past(irq_masked))
		else $error("request below in-service level acknowledged");
	chk_ack_frame: assert property (irq_ack |-> !flags_out[ccr_pkg::FB_IE]
		&& stk_we && sp_out == $past(sp_out) - 16'h0004
		&& stk_wdata[31:24] == $past(flags_out))
		else $error("acknowledge frame or enable clear wrong");
	chk_zero_flag: assert property (op_seq && op_code == ccr_pkg::OP_ALU && !op_data[16]
		|=> flags_out[ccr_pkg::FB_Z] == ($past(op_data[7:0]) == 8'h00))
		else $error("zero flag mismatch");
	chk_sp_even: assert property (sp_out[0] == 1'b0 && stk_addr[0] == 1'b0)
		else $error("stack pointer odd");
	chk_call_push: assert property (op_call
		|=> stk_we && stk_len == 3'h4 && stk_addr == sp_out
		&& sp_out == $past(sp_out) - 16'h0004 && stk_wdata[31:20] == 12'h000)
		else $error("call frame wrong");
	chk_pair_push: assert property (op_seq && op_code == ccr_pkg::OP_PUSH_PAIR
		|=> stk_len == 3'h2 && sp_out == $past(sp_out) - 16'h0002
		&& stk_wdata[15:0] == $past(op_data[15:0]))
		else $error("pair push wrong");
	chk_indirect_bank: assert property (op_seq && op_code == ccr_pkg::OP_BR_REG
		|=> pc_out[19:16] == $past(q.cext))
		else $error("indirect branch upper bits wrong");
	chk_ei_sets: assert property (op_flags_free && op_code == ccr_pkg::OP_EI
		|=> flags_out[ccr_pkg::FB_IE])
		else $error("enable flag not set");
	chk_bank_field: assert property (op_flags_free && op_code == ccr_pkg::OP_SEL_BANK
		|=> {flags_out[ccr_pkg::FB_RB1], flags_out[ccr_pkg::FB_RB0]} == $past(op_data[1:0]))
		else $error("bank select field wrong");
	chk_aux_carry: assert property (op_flags_free && op_code == ccr_pkg::OP_ALU
		|=> flags_out[ccr_pkg::FB_AC] == $past(op_data[18]))
		else $error("auxiliary carry mismatch");
	chk_carry_acc: assert property (op_flags_free && op_code == ccr_pkg::OP_CARRY
		|=> flags_out[ccr_pkg::FB_CY] == $past(op_data[0]))
		else $error("carry accumulator mismatch");
	chk_flag_pop: assert property (op_flags_free && op_code == ccr_pkg::OP_POP_FLAGS
		|=> flags_out == $past(op_data[15:8]) && sp_out == $past(sp_out) + 16'h0002)
		else $error("flag pop wrong");
	chk_ret_restore: assert property (op_flags_free && op_code == ccr_pkg::OP_RET_INT
		|=> flags_out == $past(op_data[31:24]) && pc_out == $past(op_data[19:0]))
		else $error("interrupt return restore wrong");
	chk_daddr_plain: assert property (op_seq && !op_data[16]
		&& op_code == ccr_pkg::OP_DADDR |=> data_addr == {ccr_pkg::DATA_TOP, $past(op_data[15:0])})
		else $error("plain data address not in top bank");
	chk_ack_vector: assert property (irq_ack
		|-> pc_out == {4'h0, $past(irq_vector)} && flags_out[2:1] == $past(irq_prio))
		else $error("acknowledge vector or level wrong");
endmodule

// ===== ccr_irq_model.sv
// Purpose: Interrupt requester model facing the register set
// Assumes: One source; its request is held as a level until acknowledged
// Notes: The vector line shows the inverse of its last value while idle
`timescale 1ns/1ps
module ccr_irq_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic want,
	input wire logic [1:0] prio,
	input wire logic masked,
	input wire logic [15:0] vec,
	input wire logic irq_ack,
	output logic irq_req,
	output logic irq_masked,
	output logic [1:0] irq_prio,
	output logic [15:0] irq_vector
);
	logic served_q;
	// Drop the request on acknowledge, so that one request is served once only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			served_q <= 1'b0;
			irq_req <= 1'b0;
			irq_masked <= 1'b0;
			irq_prio <= 2'h0;
			irq_vector <= 16'h0;
		end else begin
			served_q <= want & (served_q | irq_ack);
			irq_req <= want & ~served_q & ~irq_ack;
			irq_masked <= masked;
			irq_prio <= prio;
			irq_vector <= want ? vec : ~irq_vector; // Idle vector never looks valid
		end
	end
endmodule

// ===== tb_top.sv
// Purpose: Self-checking bench for the CPU control register set
// Assumes: Zero-wait bus slave; one op per strobe; fixed seed
// Notes: Expectations live in bench variables and are never read back
`timescale 1ns/1ps
module tb_top;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic op_valid = 1'b0, want = 1'b0, imask = 1'b0;
	logic [1:0] htrans = 2'h0, iprio = 2'h0, irq_prio;
	logic [3:0] op_code = 4'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, op_data = 32'h0, d, e, r, hrdata, stk_wdata;
	logic [15:0] ivec = 16'h0, sp_e, stk_addr, sp_out, irq_vector;
	logic [7:0] vlo = 8'h0, vhi = 8'h0, fl_e, flags_out;
	logic [19:0] pc_e, pc_out, data_addr;
	logic [2:0] stk_len;
	logic hreadyout, hresp, irq_ack, core_ready, stk_we, data_is_wreg, irq_req, irq_masked;
	int seed = 64635, miscompares = 0, checked = 0, i;
	always #2 hclk = ~hclk;
	ccr_core u_ccr_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .reset_vec_lo(vlo),
		.reset_vec_hi(vhi), .op_valid(op_valid), .op_code(op_code), .op_data(op_data),
		.irq_req(irq_req), .irq_masked(irq_masked), .irq_prio(irq_prio),
		.irq_vector(irq_vector), .irq_ack(irq_ack), .core_ready(core_ready), .pc_out(pc_out),
		.flags_out(flags_out), .sp_out(sp_out), .stk_we(stk_we), .stk_addr(stk_addr),
		.stk_wdata(stk_wdata), .stk_len(stk_len), .data_addr(data_addr),
		.data_is_wreg(data_is_wreg));
	ccr_irq_model u_ccr_irq_model (.hclk(hclk), .hresetn(hresetn), .want(want), .prio(iprio),
		.masked(imask), .vec(ivec), .irq_ack(irq_ack), .irq_req(irq_req),
		.irq_masked(irq_masked), .irq_prio(irq_prio), .irq_vector(irq_vector));
	// Zero flag looks at the low byte unless the op is a word op
	function logic zf(input logic [16:0] x);
		return x[16] ? (x[15:0] == 16'h0) : (x[7:0] == 8'h0);
	endfunction
	function logic [20:0] daddr_f(input logic [3:0] hi, input logic [15:0] a);
		logic [19:0] f;
		f = {hi, a};
		return {(f >= ccr_pkg::WREG_LO && f <= ccr_pkg::WREG_HI), f};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] x, input string m);
		checked++;
		if (g !== x) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, g, x);
		end
	endtask
	// One single transfer; the address phase is held until hready is seen high
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
		hsel <= 1'b0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] x, input string m);
		bus(1'b0, a, 32'h0);
		chk(r, x, m);
	endtask
	task op(input logic [3:0] c, input logic [31:0] v);
		@(posedge hclk);
		op_valid <= 1'b1;
		op_code <= c;
		op_data <= v;
		@(posedge hclk);
		op_valid <= 1'b0;
		#1;
	endtask
	// Raise one request, watch eight cycles for the acknowledge, then withdraw
	task irq(input logic [1:0] p, input logic m, input logic x);
		logic seen;
		seen = 1'b0;
		@(posedge hclk);
		want <= 1'b1;
		iprio <= p;
		imask <= m;
		ivec <= 16'($random(seed));
		repeat (8) begin
			@(posedge hclk);
			#1;
			if (irq_ack === 1'b1) seen = 1'b1;
		end
		@(posedge hclk);
		want <= 1'b0;
		chk(32'(seen), 32'(x), "irq ack");
	endtask
	task end_sim();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Watchdog sized well beyond the few hundred cycles the sequence needs
	initial begin
		#100000;
		miscompares++;
		end_sim();
	end
	// Main sequence
	initial begin
		vlo = 8'($random(seed));
		vhi = 8'($random(seed));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 20 && core_ready !== 1'b1; i++) @(posedge hclk);
		#1;
		pc_e = {4'h0, vhi, vlo};
		chk(32'(pc_out), 32'(pc_e), "boot pc");
		rc(ccr_pkg::OFS_FLAGS, 32'h06, "flags rst");
		rc(ccr_pkg::OFS_DEXT, 32'h0f, "dext rst");
		rc(ccr_pkg::OFS_CEXT, 32'h00, "cext rst");
		bus(1'b1, 8'h30, 32'hffffffff);
		rc(8'h30, 32'h0, "unmapped");
		chk(32'(hresp), 32'h0, "hresp");
		fl_e = 8'h06;
		// Stack is set up before any push, kept clear of the bank area
		sp_e = 16'hf000 | (16'($random(seed)) & 16'h0dfe);
		op(ccr_pkg::OP_LOAD_SP, 32'(sp_e | 16'h1));
		chk(32'(sp_out), 32'(sp_e), "sp even");
		rc(ccr_pkg::OFS_SP, 32'(sp_e), "sp read");
		for (i = 0; i < 4; i++) begin
			op(ccr_pkg::OP_SEQ, 32'(i + 1));
			pc_e = pc_e + 20'(i + 1);
			chk(32'(pc_out), 32'(pc_e), "seq pc");
		end
		d = $random(seed);
		op(ccr_pkg::OP_BR, d);
		pc_e = d[19:0];
		chk(32'(pc_out), 32'(pc_e), "br pc");
		rc(ccr_pkg::OFS_PC, 32'(pc_e), "pc read");
		bus(1'b1, ccr_pkg::OFS_CEXT, d);
		rc(ccr_pkg::OFS_CEXT, 32'(d[3:0]), "cext");
		e = $random(seed);
		op(ccr_pkg::OP_BR_REG, e);
		pc_e = {d[3:0], e[15:0]};
		chk(32'(pc_out), 32'(pc_e), "br reg");
		e = $random(seed);
		op(ccr_pkg::OP_CALL, e);
		sp_e = sp_e - 16'h4;
		chk(stk_wdata, {12'h0, pc_e}, "call frame");
		chk(32'({stk_we, stk_len, stk_addr}), 32'({1'b1, 3'h4, sp_e}), "call");
		pc_e = e[19:0];
		chk(32'(pc_out), 32'(pc_e), "call pc");
		@(posedge hclk);
		#1;
		chk(32'(stk_we), 32'h0, "we pulse");
		e = $random(seed);
		op(ccr_pkg::OP_PUSH_PAIR, e);
		sp_e = sp_e - 16'h2;
		chk({stk_addr, stk_wdata[15:0]}, {sp_e, e[15:0]}, "pair push");
		// A zero low word at random width and a byte-width zero with a nonzero high byte are forced among random ones
		for (i = 0; i < 8; i++) begin
			d = $random(seed);
			if (i == 0) d[15:0] = 16'h0;
			if (i == 1) d[16:0] = 17'h0ff00;
			op(ccr_pkg::OP_ALU, d);
			fl_e[ccr_pkg::FB_Z] = zf(d[16:0]);
			fl_e[ccr_pkg::FB_CY] = d[17];
			fl_e[ccr_pkg::FB_AC] = d[18];
			chk(32'(flags_out), 32'(fl_e), "alu");
		end
		op(ccr_pkg::OP_CARRY, 32'h1);
		fl_e[ccr_pkg::FB_CY] = 1'b1;
		chk(32'(flags_out), 32'(fl_e), "bit acc");
		op(ccr_pkg::OP_PUSH_FLAGS, 32'h0);
		sp_e = sp_e - 16'h2;
		chk({stk_addr, stk_wdata[15:0]}, {sp_e, fl_e, 8'h0}, "flag push");
		e = $random(seed);
		op(ccr_pkg::OP_POP_FLAGS, e);
		sp_e = sp_e + 16'h2;
		fl_e = e[15:8];
		chk({sp_out, 8'h0, flags_out}, {sp_e, 8'h0, fl_e}, "flag pop");
		// Every bank; pair i of bank i is built from two byte writes
		for (i = 0; i < 4; i++) begin
			op(ccr_pkg::OP_SEL_BANK, 32'(i));
			fl_e[ccr_pkg::FB_RB1] = i[1];
			fl_e[ccr_pkg::FB_RB0] = i[0];
			chk(32'(flags_out), 32'(fl_e), "bank");
			d = $random(seed);
			bus(1'b1, ccr_pkg::OFS_WREG + 8'(i * 40 + 4), d);
			bus(1'b1, ccr_pkg::OFS_WREG + 8'(i * 40), d >> 8);
			rc(ccr_pkg::OFS_PAIR + 8'(i * 4), {16'h0, d[7:0], d[15:8]}, "pair");
		end
		d = $random(seed);
		bus(1'b1, ccr_pkg::OFS_DEXT, d);
		for (i = 0; i < 4; i++) begin
			e = $random(seed);
			e[16] = (i == 1);
			if (i > 1) e[15:0] = (i == 2) ? 16'hfee0 : 16'hfeff;
			op(ccr_pkg::OP_DADDR, e);
			r = 32'(daddr_f(e[16] ? d[3:0] : ccr_pkg::DATA_TOP, e[15:0]));
			chk(32'({data_is_wreg, data_addr}), r, "daddr");
			rc(ccr_pkg::OFS_DADDR, r, "daddr read");
		end
		op(ccr_pkg::OP_DI, 32'h0);
		chk(32'(flags_out[ccr_pkg::FB_IE]), 32'h0, "di");
		irq(2'h0, 1'b0, 1'b0);
		op(ccr_pkg::OP_EI, 32'h0);
		chk(32'(flags_out[ccr_pkg::FB_IE]), 32'h1, "ei");
		irq(2'h0, 1'b1, 1'b0);
		bus(1'b1, ccr_pkg::OFS_FLAGS, 32'h82);
		irq(2'h2, 1'b0, 1'b0);
		irq(2'h1, 1'b0, 1'b1);
		sp_e = sp_e - 16'h4;
		chk({stk_addr, 16'h0}, {sp_e, 16'h0}, "ack sp");
		chk(stk_wdata, {8'h82, 4'h0, pc_e}, "ack frame");
		chk(32'(flags_out), 32'h02, "ack flags");
		chk(32'(pc_out), 32'(ivec), "ack pc");
		e = $random(seed);
		op(ccr_pkg::OP_RET_INT, e);
		sp_e = sp_e + 16'h4;
		chk({sp_out, flags_out, 8'h0}, {sp_e, e[31:24], 8'h0}, "interrupt_return_instruction");
		chk(32'(pc_out), 32'(e[19:0]), "interrupt_return_instruction pc");
		end_sim();
	end
endmodule
